// [include/rgfd_map.vh]
`ifndef RGFD_MAP_VH
`define RGFD_MAP_VH

// register indices; byte address is four times the index
`define RGFD_IDX_TUNE 12'h430
`define RGFD_IDX_FIFO 12'h601
`define RGFD_IDX_DLY 12'h602
`define RGFD_IDX_CTRL 12'h603
`define RGFD_IDX_IMASK 12'h604
`define RGFD_IDX_W 12

// fifo error flag bits
`define RGFD_TX_UNF 0
`define RGFD_TX_OVF 1
`define RGFD_RX_UNF 2
`define RGFD_RX_OVF 3
`define RGFD_FLAGS_W 4

// delay select bits
`define RGFD_TX_DLY 0
`define RGFD_RX_DLY 1
`define RGFD_DLY_W 2

// tuning register fields
`define RGFD_RX_TUNE_LO 4
`define RGFD_RX_TUNE_HI 7
`define RGFD_TX_TUNE_LO 8
`define RGFD_TX_TUNE_HI 11
`define RGFD_TUNE_W 12
`define RGFD_TUNE_RST 12'h000

// control register bits
`define RGFD_CTRL_SUP 0
`define RGFD_CTRL_FD 1
`define RGFD_CTRL_W 2

`define RGFD_REG_W 16
`define RGFD_ZERO16 16'h0000
`define RGFD_UNMAPPED 32'h00000000
`define RGFD_TAPS 16

`endif

// [design/rgfd_sync.v]
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser for a level; the first stage feeds only the second
module rgfd_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk) begin
        meta_q <= d;
        sync_q <= meta_q;
    end

    assign q = sync_q;
endmodule

`default_nettype wire

// [design/rgfd_delay.v]
`timescale 1ns/10ps
`default_nettype none

// tap line; when enabled the output is the input taken tap+2 samples late
module rgfd_delay #(
    parameter TAPS = 16
) (
    input wire clk,
    input wire srst,
    input wire enable,
    input wire [3:0] tap,
    input wire d,
    output reg q
);
    reg [TAPS-1:0] line_q;

    always @(posedge clk) begin
        if (srst) begin
            line_q <= {TAPS{1'b0}};
            q <= 1'b0;
        end else begin
            line_q <= {line_q[TAPS-2:0], d};
            q <= enable ? line_q[tap] : d;
        end
    end
endmodule

`default_nettype wire

// [design/rgfd_top.v]
// How it works
// - suppress control set: drop mac tx error in full duplex while tx enable low
// - rx fifo overflow sets sticky flag bit 3, cleared by writing zero
// - rx fifo underflow sets sticky flag bit 2, cleared by writing zero
// - tx fifo overflow sets sticky flag bit 1, cleared by writing zero
// - tx fifo underflow sets sticky bit 0; all flags reset to zero
// - rx delay select shifts outgoing rx clock against rx data
// - rx delay size comes from tuning register bits 7 to 4
// - tx delay select delays incoming tx clock before data sampling
// - tx delay size comes from tuning register bits 11 to 8
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "rgfd_map.vh"

module rgfd_top (
    input wire CLK,
    input wire SRST,
    input wire [13:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    output wire IRQ,
    input wire RX_FIFO_OVERFLOW,
    input wire RX_FIFO_UNDERFLOW,
    input wire TX_FIFO_OVERFLOW,
    input wire TX_FIFO_UNDERFLOW,
    input wire MAC_TX_CLK,
    input wire MAC_TX_EN,
    input wire MAC_TX_ERR,
    output reg TX_ERR_OUT,
    output wire TX_SAMPLE_CLK,
    input wire RX_CLK_IN,
    output wire RX_CLK_OUT
);
    wire [3:0] ev_sync;
    wire [2:0] link_sync;
    wire rx_clk_sync;
    reg [3:0] ev_prev_q;
    reg [`RGFD_FLAGS_W-1:0] flags_q;
    reg [`RGFD_FLAGS_W-1:0] flags_d;
    reg [`RGFD_FLAGS_W-1:0] irq_st_q;
    reg [`RGFD_FLAGS_W-1:0] irq_st_d;
    reg [`RGFD_FLAGS_W-1:0] mask_q;
    reg [`RGFD_DLY_W-1:0] dly_q;
    reg [`RGFD_TUNE_W-1:0] tune_q;
    reg [`RGFD_CTRL_W-1:0] ctrl_q;
    reg ack_q;
    wire [`RGFD_FLAGS_W-1:0] ev_pulse;
    wire [`RGFD_IDX_W-1:0] idx;
    wire req;
    wire wr_lo;
    wire wr_hi;
    wire take;
    wire tx_clk_s;
    wire tx_en_s;
    wire tx_err_s;

    // fifo events arrive from the link side; edge-detect after sync
    rgfd_sync #(.W(4)) u_ev_sync (
        .clk(CLK),
        .d({RX_FIFO_OVERFLOW, RX_FIFO_UNDERFLOW,
            TX_FIFO_OVERFLOW, TX_FIFO_UNDERFLOW}),
        .q(ev_sync)
    );

    rgfd_sync #(.W(3)) u_link_sync (
        .clk(CLK),
        .d({MAC_TX_CLK, MAC_TX_EN, MAC_TX_ERR}),
        .q(link_sync)
    );

    rgfd_sync #(.W(1)) u_rxc_sync (
        .clk(CLK),
        .d(RX_CLK_IN),
        .q(rx_clk_sync)
    );

    assign tx_clk_s = link_sync[2];
    assign tx_en_s = link_sync[1];
    assign tx_err_s = link_sync[0];

    always @(posedge CLK) begin
        if (SRST) begin
            ev_prev_q <= 4'h0;
        end else begin
            ev_prev_q <= ev_sync;
        end
    end

    assign ev_pulse = {ev_sync[3] & ~ev_prev_q[3], ev_sync[2] & ~ev_prev_q[2],
                       ev_sync[1] & ~ev_prev_q[1], ev_sync[0] & ~ev_prev_q[0]};

    // one wait state: answer at the second edge of each request
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign take = req & ack_q;
    assign idx = AVS_ADDRESS[13:2];
    assign wr_lo = take & AVS_WRITE & AVS_BYTEENABLE[0];
    assign wr_hi = take & AVS_WRITE & AVS_BYTEENABLE[1];

    always @(posedge CLK) begin
        if (SRST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // sticky flags: write-zero clears, a same-cycle event wins
    always @* begin
        flags_d = flags_q;
        if (wr_lo && idx == `RGFD_IDX_FIFO) begin
            flags_d = flags_q & AVS_WRITEDATA[`RGFD_FLAGS_W-1:0];
        end
        flags_d[`RGFD_RX_OVF] = flags_d[`RGFD_RX_OVF] |
                                ev_pulse[`RGFD_RX_OVF];
        flags_d[`RGFD_RX_UNF] = flags_d[`RGFD_RX_UNF] |
                                ev_pulse[`RGFD_RX_UNF];
        flags_d[`RGFD_TX_OVF] = flags_d[`RGFD_TX_OVF] |
                                ev_pulse[`RGFD_TX_OVF];
        flags_d[`RGFD_TX_UNF] = flags_d[`RGFD_TX_UNF] |
                                ev_pulse[`RGFD_TX_UNF];
    end

    // interrupt status: read clears, event wins
    always @* begin
        irq_st_d = irq_st_q;
        if (take && AVS_READ && idx == `RGFD_IDX_IMASK) begin
            irq_st_d = {`RGFD_FLAGS_W{1'b0}};
        end
        irq_st_d = irq_st_d | ev_pulse;
    end

    assign IRQ = |(irq_st_q & mask_q);

    always @(posedge CLK) begin
        if (SRST) begin
            flags_q <= {`RGFD_FLAGS_W{1'b0}};
            irq_st_q <= {`RGFD_FLAGS_W{1'b0}};
            mask_q <= {`RGFD_FLAGS_W{1'b0}};
            dly_q <= {`RGFD_DLY_W{1'b0}};
            tune_q <= `RGFD_TUNE_RST;
            ctrl_q <= {`RGFD_CTRL_W{1'b0}};
        end else begin
            flags_q <= flags_d;
            irq_st_q <= irq_st_d;
            if (wr_lo && idx == `RGFD_IDX_DLY) begin
                dly_q <= AVS_WRITEDATA[`RGFD_DLY_W-1:0];
            end
            if (wr_lo && idx == `RGFD_IDX_CTRL) begin
                ctrl_q <= AVS_WRITEDATA[`RGFD_CTRL_W-1:0];
            end
            if (wr_lo && idx == `RGFD_IDX_IMASK) begin
                mask_q <= AVS_WRITEDATA[`RGFD_FLAGS_W-1:0];
            end
            if (wr_lo && idx == `RGFD_IDX_TUNE) begin
                tune_q[7:0] <= AVS_WRITEDATA[7:0];
            end
            if (wr_hi && idx == `RGFD_IDX_TUNE) begin
                tune_q[`RGFD_TUNE_W-1:8] <= AVS_WRITEDATA[`RGFD_TUNE_W-1:8];
            end
        end
    end

    // read data registered at the waiting edge, before the answer; reserved bits zero
    always @(posedge CLK) begin
        if (SRST) begin
            AVS_READDATA <= `RGFD_UNMAPPED;
        end else if (AVS_READ && !ack_q) begin
            case (idx)
                `RGFD_IDX_FIFO: AVS_READDATA <= {28'h0000000, flags_q};
                `RGFD_IDX_DLY: AVS_READDATA <= {30'h0, dly_q};
                `RGFD_IDX_TUNE: AVS_READDATA <= {20'h00000, tune_q};
                `RGFD_IDX_CTRL: AVS_READDATA <= {30'h0, ctrl_q};
                `RGFD_IDX_IMASK: AVS_READDATA <= {24'h000000, irq_st_q,
                                                 mask_q};
                default: AVS_READDATA <= `RGFD_UNMAPPED;
            endcase
        end
    end

    // tx error filter; mac clock edge alignment is the mac's concern
    always @(posedge CLK) begin
        if (SRST) begin
            TX_ERR_OUT <= 1'b0;
        end else if (ctrl_q[`RGFD_CTRL_SUP] && ctrl_q[`RGFD_CTRL_FD] &&
                     !tx_en_s) begin
            TX_ERR_OUT <= 1'b0;
        end else begin
            TX_ERR_OUT <= tx_err_s;
        end
    end

    // delay lines in CLK samples stand in for the analog quarter-cycle tap
    rgfd_delay #(.TAPS(`RGFD_TAPS)) u_tx_dly (
        .clk(CLK),
        .srst(SRST),
        .enable(dly_q[`RGFD_TX_DLY]),
        .tap(tune_q[`RGFD_TX_TUNE_HI:`RGFD_TX_TUNE_LO]),
        .d(tx_clk_s),
        .q(TX_SAMPLE_CLK)
    );

    rgfd_delay #(.TAPS(`RGFD_TAPS)) u_rx_dly (
        .clk(CLK),
        .srst(SRST),
        .enable(dly_q[`RGFD_RX_DLY]),
        .tap(tune_q[`RGFD_RX_TUNE_HI:`RGFD_RX_TUNE_LO]),
        .d(rx_clk_sync),
        .q(RX_CLK_OUT)
    );
endmodule

`default_nettype wire

// [verification/rgfd_mac_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rgfd_mac_model (
    input wire logic run,
    input wire logic en_req,
    input wire logic err_req,
    output logic tx_clk,
    output logic tx_en,
    output logic tx_err,
    output logic rx_clk
);
    initial begin
        tx_clk = 1'b0;
        rx_clk = 1'b0;
        tx_en = 1'b0;
        tx_err = 1'b0;
        #1.3;
        forever begin
            #40;
            if (run) begin
                tx_clk = !tx_clk;
                rx_clk = tx_clk;
            end
        end
    end
    // mac launches data with the clock edge, hence asks for delay
    always @(posedge tx_clk) begin
        tx_en <= en_req;
        tx_err <= err_req;
    end
endmodule
`default_nettype wire

// [verification/rgfd_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rgfd_map.vh"
module rgfd_monitor (
    input wire CLK,
    input wire SRST,
    input wire [13:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    input wire MAC_TX_EN,
    input wire MAC_TX_ERR,
    input wire TX_ERR_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    wire [11:0] idx = AVS_ADDRESS[13:2];
    wire done = AVS_READ && !AVS_WAITREQUEST;
    sequence req_rise;
        $rose(AVS_READ || AVS_WRITE);
    endsequence
    sequence one_wait;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    wait_once_a: assert property (req_rise |-> one_wait)
        else $error("bus answer not after one wait");
    idle_ready_a: assert property (!(AVS_READ || AVS_WRITE)
        |-> !AVS_WAITREQUEST) else $error("wait without request");
    unmapped_zero_a: assert property (done &&
        idx > `RGFD_IDX_IMASK |-> AVS_READDATA == 0)
        else $error("unmapped read");
    flag_rsvd_a: assert property (done &&
        idx == `RGFD_IDX_FIFO |-> AVS_READDATA[31:4] == 0)
        else $error("flag spare");
    dly_rsvd_a: assert property (done &&
        idx == `RGFD_IDX_DLY |-> AVS_READDATA[31:2] == 0)
        else $error("dly spare");
    hold_data_a: assert property (!AVS_READ |=>
        $stable(AVS_READDATA)) else $error("read data moved");
    err_pass_a: assert property ($past(MAC_TX_EN, 3) &&
        $past(MAC_TX_ERR, 3) |-> TX_ERR_OUT) else $error("err lost");
    err_idle_a: assert property (!$past(MAC_TX_ERR, 3)
        |-> !TX_ERR_OUT) else $error("spurious err");
endmodule
bind rgfd_top rgfd_monitor mon (.CLK, .SRST, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .MAC_TX_EN,
    .MAC_TX_ERR, .TX_ERR_OUT);
`default_nettype wire

// [verification/rgfd_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rgfd_map.vh"
module rgfd_tb_top;
    logic CLK, SRST = 1, AVS_READ = 0, AVS_WRITE = 0, run = 0, en = 0;
    logic err = 0;
    logic [13:0] AVS_ADDRESS = 0;
    logic [31:0] AVS_WRITEDATA = 0, rd, lfsr_q = 32'h54FB;
    logic [3:0] AVS_BYTEENABLE = 0, ev = 0;
    wire [31:0] AVS_READDATA;
    wire AVS_WAITREQUEST, IRQ, TX_ERR_OUT, TX_SAMPLE_CLK, RX_CLK_OUT;
    wire MAC_TX_CLK, MAC_TX_EN, MAC_TX_ERR, RX_CLK_IN;
    int n_errors = 0, n_tests = 0, cyc = 0, n, b, flags = 0;
    rgfd_top dut (.CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
        .AVS_WAITREQUEST, .IRQ, .RX_FIFO_OVERFLOW(ev[3]),
        .RX_FIFO_UNDERFLOW(ev[2]), .TX_FIFO_OVERFLOW(ev[1]),
        .TX_FIFO_UNDERFLOW(ev[0]), .MAC_TX_CLK, .MAC_TX_EN, .MAC_TX_ERR,
        .TX_ERR_OUT, .TX_SAMPLE_CLK, .RX_CLK_IN, .RX_CLK_OUT);
    rgfd_mac_model mac (.run, .en_req(en), .err_req(err),
        .tx_clk(MAC_TX_CLK), .tx_en(MAC_TX_EN), .tx_err(MAC_TX_ERR),
        .rx_clk(RX_CLK_IN));
    initial begin
        CLK = 1'b0;
        forever #2 CLK = !CLK;
    end
    task final_report;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            final_report;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], ^(s & 32'h80200003)};
    endfunction
    // request held until the edge that sees waitrequest low; data taken there
    task acc(input logic w, input logic [11:0] i, input logic [31:0] d);
        AVS_ADDRESS <= {i, 2'b00};
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= 4'hF;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask
    task rdchk(input logic [11:0] i, input logic [31:0] exp);
        acc(0, i, 0);
        chk(rd, exp);
    endtask
    // cycles from a link clock rise to the matching rise at the output
    task lat(input logic rx, output int k);
        logic p, q;
        @(posedge MAC_TX_CLK);
        p = 1'b1;
        for (k = 1; k < 40; k++) begin
            @(posedge CLK);
            #1;
            q = rx ? RX_CLK_OUT : TX_SAMPLE_CLK;
            if (q === 1'b1 && p === 1'b0)
                break;
            p = q;
        end
        @(posedge CLK);
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        rdchk(`RGFD_IDX_FIFO, 0);
        rdchk(`RGFD_IDX_DLY, 0);
        acc(1, `RGFD_IDX_DLY, 32'hFFFFFFFF);
        rdchk(`RGFD_IDX_DLY, 3);
        rdchk(12'hFFF, 0);
        acc(1, `RGFD_IDX_IMASK, 5);
        for (b = 0; b < 4; b++) begin
            ev[b] <= 1'b1;
            repeat (2) @(posedge CLK);
            ev[b] <= 1'b0;
            repeat (7) @(posedge CLK);
            flags |= 1 << b;
            chk(IRQ, (5 >> b) & 1);
            rdchk(`RGFD_IDX_FIFO, flags);
            rdchk(`RGFD_IDX_IMASK, (16 << b) | 5);
            chk(IRQ, 0);
        end
        acc(1, `RGFD_IDX_FIFO, 5);
        rdchk(`RGFD_IDX_FIFO, 5);
        acc(1, `RGFD_IDX_FIFO, 0);
        rdchk(`RGFD_IDX_FIFO, 0);
        run <= 1'b1;
        for (b = 0; b < 8; b++) begin
            acc(1, `RGFD_IDX_CTRL, b & 3);
            en <= b[2];
            err <= 1'b1;
            repeat (50) @(posedge CLK);
            chk(TX_ERR_OUT, !(b == 3));
        end
        err <= 1'b0;
        for (b = 0; b < 4; b++) begin
            lfsr_q = lfsr_next(lfsr_q);
            acc(1, `RGFD_IDX_TUNE, lfsr_q);
            rdchk(`RGFD_IDX_TUNE, lfsr_q[11:0]);
            acc(1, `RGFD_IDX_DLY, b);
            lat(0, n);
            chk(n, 3 + (b[0] ? lfsr_q[11:8] + 1 : 0));
            lat(1, n);
            chk(n, 3 + (b[1] ? lfsr_q[7:4] + 1 : 0));
        end
        final_report;
    end
endmodule
`default_nettype wire
